// ===== hw/pss_burst_ctr.sv
// Two-bit burst counter producing the low address bits of each access.
// Assumes load and advance are already qualified and never both high.
`timescale 1ns/1ps
module pss_burst_ctr (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core side
  pss_core_if.ctr core
);
  import pss_pkg::*;

  logic [BURST_W-1:0] base;
  logic [BURST_W-1:0] offset;
  logic [BURST_W-1:0] next_base;
  logic [BURST_W-1:0] next_offset;

  always_comb begin
    next_base = core.ctrLoad ? core.ctrBase : base;
    next_offset = offset;
    if (core.ctrLoad) begin
      next_offset = BURST_RST;
    end else if (core.ctrAdvance) begin
      next_offset = offset + BURST_STEP;
    end
  end

  // Wraps within four words in either order
  assign core.ctrLow = core.ctrLinear ? next_base + next_offset : next_base ^ next_offset;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      base <= BURST_RST;
      offset <= BURST_RST;
    end else begin
      base <= next_base;
      offset <= next_offset;
    end
  end

endmodule

// ===== hw/pss_core_if.sv
// Carrier between the port controller, the storage array and the burst counter.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface pss_core_if;
  import pss_pkg::*;

  // Self-timed write port
  logic wrEn;
  pss_addr_t wrAddr;
  pss_lanes_t wrLanes;
  pss_word_t wrData;
  // Read port
  pss_addr_t rdAddr;
  pss_word_t rdData;
  // Burst counter
  logic ctrLoad;
  logic ctrAdvance;
  logic ctrLinear;
  logic [BURST_W-1:0] ctrBase;
  logic [BURST_W-1:0] ctrLow;

  modport port (
    output wrEn, wrAddr, wrLanes, wrData, rdAddr, ctrLoad, ctrAdvance, ctrLinear, ctrBase,
    input rdData, ctrLow
  );
  modport mem (
    input wrEn, wrAddr, wrLanes, wrData, rdAddr,
    output rdData
  );
  modport ctr (
    input ctrLoad, ctrAdvance, ctrLinear, ctrBase,
    output ctrLow
  );
endinterface

// ===== hw/pss_mem_array.sv
// Flip-flop storage of 128K words of 36 bits with per-lane writes.
// Assumes the controller raises wrEn for exactly one edge per write.
`timescale 1ns/1ps
module pss_mem_array (
  // Clock
  input wire logic mclk,
  // Core side
  pss_core_if.mem core
);
  import pss_pkg::*;

  pss_word_t store [DEPTH];

  // Contents survive reset and sleep, so no reset term here
  always_ff @(posedge mclk) begin
    if (core.wrEn) begin
      store[core.wrAddr] <= pss_merge(store[core.wrAddr], core.wrLanes, core.wrData);
    end
  end

  assign core.rdData = store[core.rdAddr];

endmodule

// ===== hw/pss_pkg.sv
// Shared constants, types and lane merge for the pipelined SRAM port.
// Assumes one clock domain; every file but the checker imports this package whole.
package pss_pkg;

  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int WORD_W = DATA_W + LANES;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BURST_W = 2;
  localparam int UPPER_W = ADDR_W - BURST_W;

  // Values after reset, and the burst counter step
  localparam logic OUT_EN_N_RST = 1'b1;
  localparam logic SLEEP_RST = 1'b0;
  localparam logic MODE_RST = 1'b1;
  localparam logic DRIVE_RST = 1'b0;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // Cycles through the two-stage synchroniser on asynchronous pins
  localparam int SYNC_CYCLES = 2;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } pss_op_t;

  typedef logic [ADDR_W-1:0] pss_addr_t;
  typedef logic [WORD_W-1:0] pss_word_t;
  typedef logic [LANES-1:0] pss_lanes_t;

  // Word layout: data lanes in [31:0], parity bit of lane i at DATA_W + i
  function automatic pss_word_t pss_merge(input pss_word_t oldWord, input pss_lanes_t enable,
                                          input pss_word_t newWord);
    pss_word_t result;
    result = oldWord;
    for (int i = 0; i < LANES; i++) begin
      if (enable[i]) begin
        result[i*BYTE_W +: BYTE_W] = newWord[i*BYTE_W +: BYTE_W];
        result[DATA_W + i] = newWord[DATA_W + i];
      end
    end
    return result;
  endfunction

endpackage

// ===== hw/pss_sram_port.sv
// Pipelined zero-turnaround burst SRAM: input registers, access pipeline,
// forwarding of pending writes, registered read data and bus tristate control.
// Assumes the memory controller runs on mclk; oe, sleep and mode pins are asynchronous.
`timescale 1ns/1ps

// Function
// - Edges act only while qualifier low
// - Qualifier high stretches cycle, no deselect
// - Sleep input enters contents-preserving sleep
// - Data inputs captured into data register
// - Drive read data only while oe low
// - Float on write data, after deselect
// - Parity lanes follow their byte strobes
// - Mode strap picks linear or interleaved
// - All synchronous inputs registered on rise
// - Read data launched from output registers
// - Access needs all three chip selects
// - Address latched when selected and loading
// - Write strobe decides write or read
// - Partial writes keep unselected lanes
// - Writes self-timed internally
// - Deselects share the access pipeline
// - Back-to-back reads and writes, no waits
// - Selects one and three low, two high
// - Advance steps two-bit burst counter
// - Byte strobes low, only with write
module pss_sram_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Synchronous control
  input wire logic clkQualifyN,
  input wire logic chipSel1N,
  input wire logic chipSel2,
  input wire logic chipSel3N,
  input wire logic advanceLoad,
  input wire logic writeN,
  input wire pss_pkg::pss_lanes_t laneWrN,
  input wire pss_pkg::pss_addr_t addr,
  // Asynchronous control and strap
  input wire logic outEnN,
  input wire logic sleepReq,
  input wire logic burstMode,
  // Data lanes
  input wire logic [pss_pkg::DATA_W-1:0] dqIn,
  output logic [pss_pkg::DATA_W-1:0] dqOut,
  output logic dqOe,
  // Parity lanes
  input wire pss_pkg::pss_lanes_t parityIoIn,
  output pss_pkg::pss_lanes_t parityIoOut,
  output logic parityIoOe,
  // Status
  output logic sleepActive
);
  import pss_pkg::*;

  pss_core_if core ();

  // Qualified edge and decoded select
  logic qualified;
  logic selected;
  logic loadCycle;
  logic advanceCycle;

  // Asynchronous pin synchronisers
  logic outEnNMeta;
  logic outEnNSync;
  logic sleepMeta;
  logic sleepSync;
  logic modeMeta;
  logic modeSync;

  // Burst context
  pss_op_t burstOp;
  logic [UPPER_W-1:0] burstUpper;

  // Address stage
  pss_op_t acc1Op;
  pss_addr_t acc1Addr;
  pss_lanes_t acc1Lanes;
  pss_op_t next_acc1Op;

  // Data phase stage
  pss_op_t acc2Op;
  pss_addr_t acc2Addr;
  pss_lanes_t acc2Lanes;

  // Commit stage
  logic wr3Valid;
  pss_addr_t wr3Addr;
  pss_lanes_t wr3Lanes;
  pss_word_t dataReg;

  // Read return
  pss_word_t fwdWord;
  pss_word_t pinWord;
  logic readPhase;
  logic next_readPhase;
  logic next_drive;

  assign qualified = ~clkQualifyN;
  assign selected = ~chipSel1N & chipSel2 & ~chipSel3N;
  assign loadCycle = qualified & ~advanceLoad;
  assign advanceCycle = qualified & advanceLoad;
  assign pinWord = {parityIoIn, dqIn};

  // Two flops each; only the second is read by logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outEnNMeta <= OUT_EN_N_RST;
      outEnNSync <= OUT_EN_N_RST;
    end else begin
      outEnNMeta <= outEnN;
      outEnNSync <= outEnNMeta;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleepMeta <= SLEEP_RST;
      sleepSync <= SLEEP_RST;
    end else begin
      sleepMeta <= sleepReq;
      sleepSync <= sleepMeta;
    end
  end

  // Floating strap reads as interleaved via reset value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modeMeta <= MODE_RST;
      modeSync <= MODE_RST;
    end else begin
      modeMeta <= burstMode;
      modeSync <= modeMeta;
    end
  end

  // Burst counter hookup
  assign core.ctrLoad = loadCycle & selected;
  assign core.ctrAdvance = advanceCycle;
  assign core.ctrLinear = ~modeSync;
  assign core.ctrBase = addr[BURST_W-1:0];

  pss_burst_ctr burstCtr (
    .mclk(mclk),
    .rst(rst),
    .core(core.ctr)
  );

  pss_mem_array memArray (
    .mclk(mclk),
    .core(core.mem)
  );

  // Kind of access entering the pipeline this edge
  always_comb begin
    next_acc1Op = acc1Op;
    if (qualified) begin
      if (sleepSync) begin
        next_acc1Op = OP_IDLE;
      end else if (advanceCycle) begin
        next_acc1Op = burstOp;
      end else if (selected) begin
        next_acc1Op = writeN ? OP_READ : OP_WRITE;
      end else begin
        next_acc1Op = OP_IDLE;
      end
    end
  end

  // Burst context holds the type of the last load and the upper address of the last selected load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      burstOp <= OP_IDLE;
      burstUpper <= '0;
    end else if (loadCycle) begin
      burstOp <= (selected && !sleepSync) ? next_acc1Op : OP_IDLE;
      if (selected) begin
        burstUpper <= addr[ADDR_W-1:BURST_W];
      end
    end
  end

  // Address stage is the input register for control and address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc1Op <= OP_IDLE;
      acc1Addr <= '0;
      acc1Lanes <= '0;
    end else if (qualified) begin
      acc1Op <= next_acc1Op;
      if (loadCycle && selected) begin
        acc1Addr <= {addr[ADDR_W-1:BURST_W], core.ctrLow};
      end else if (advanceCycle) begin
        acc1Addr <= {burstUpper, core.ctrLow};
      end
      acc1Lanes <= writeN && !advanceCycle ? '0 : ~laneWrN;
    end
  end

  // Data phase stage; a write here owns the bus for its data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc2Op <= OP_IDLE;
      acc2Addr <= '0;
      acc2Lanes <= '0;
    end else if (qualified) begin
      acc2Op <= acc1Op;
      acc2Addr <= acc1Addr;
      acc2Lanes <= acc1Lanes;
    end
  end

  // Data captured on every qualified edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dataReg <= '0;
    end else if (qualified) begin
      dataReg <= pinWord;
    end
  end

  // Commit stage; held across a stretched cycle until one qualified edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr3Valid <= 1'b0;
      wr3Addr <= '0;
      wr3Lanes <= '0;
    end else if (qualified) begin
      wr3Valid <= acc2Op == OP_WRITE;
      wr3Addr <= acc2Addr;
      wr3Lanes <= acc2Lanes;
    end
  end

  // Self-timed write, no external pulse
  assign core.wrEn = wr3Valid & qualified;
  assign core.wrAddr = wr3Addr;
  assign core.wrLanes = wr3Lanes;
  assign core.wrData = dataReg;
  assign core.rdAddr = acc1Addr;

  // Newer pending writes override older data so back-to-back turns stay coherent
  always_comb begin
    fwdWord = core.rdData;
    if (wr3Valid && wr3Addr == acc1Addr) begin
      fwdWord = pss_merge(fwdWord, wr3Lanes, dataReg);
    end
    if (acc2Op == OP_WRITE && acc2Addr == acc1Addr) begin
      fwdWord = pss_merge(fwdWord, acc2Lanes, pinWord);
    end
  end

  // Output data register, changes only after a qualified rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dqOut <= '0;
      parityIoOut <= '0;
    end else if (qualified && acc1Op == OP_READ) begin
      dqOut <= fwdWord[DATA_W-1:0];
      parityIoOut <= fwdWord[WORD_W-1:DATA_W];
    end
  end

  always_comb begin
    next_readPhase = readPhase;
    if (qualified) begin
      unique case (acc1Op)
        OP_READ: next_readPhase = 1'b1;
        OP_WRITE: next_readPhase = 1'b0;
        OP_IDLE: next_readPhase = 1'b0;
      endcase
    end
  end

  // Enable recomputed every edge so oe and sleep act during a stretch
  assign next_drive = next_readPhase & ~outEnNSync & ~sleepSync;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readPhase <= DRIVE_RST;
      dqOe <= DRIVE_RST;
      parityIoOe <= DRIVE_RST;
    end else begin
      readPhase <= next_readPhase;
      dqOe <= next_drive;
      parityIoOe <= next_drive;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleepActive <= SLEEP_RST;
    end else begin
      sleepActive <= sleepSync;
    end
  end

endmodule

// ===== tb/pss_host_model.sv
// Host side of the shared lines: drives write data and resolves the wire.
// Released lines show the inverse of their last driven value.
`timescale 1ns/1ps
module pss_host_model (
  // Device side
  input wire logic [pss_pkg::DATA_W-1:0] dqOut,
  input wire pss_pkg::pss_lanes_t parityIoOut,
  input wire logic dqOe,
  // Host side
  input wire pss_pkg::pss_word_t hostWord,
  input wire logic hostDrv,
  // Wire
  output pss_pkg::pss_word_t busWord
);
  import pss_pkg::*;
  pss_word_t last;
  always @* begin
    if (dqOe) last = {parityIoOut, dqOut};
    else if (hostDrv) last = hostWord;
    if (dqOe && hostDrv) busWord = 'x;
    else if (dqOe || hostDrv) busWord = last;
    else busWord = ~last;
  end
endmodule

// ===== tb/pss_sram_port_asserts.sv
// Checker on the SRAM port pins: bus drive, stall and sleep relations.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module pss_sram_port_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus controls
  input wire logic clkQualifyN,
  input wire logic chipSel1N,
  input wire logic chipSel2,
  input wire logic chipSel3N,
  input wire logic advanceLoad,
  input wire logic writeN,
  input wire logic outEnN,
  input wire logic sleepReq,
  // Outputs
  input wire logic [pss_pkg::DATA_W-1:0] dqOut,
  input wire pss_pkg::pss_lanes_t parityIoOut,
  input wire logic dqOe,
  input wire logic parityIoOe,
  input wire logic sleepActive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire selOk = !chipSel1N && chipSel2 && !chipSel3N;
  wire load = !clkQualifyN && !advanceLoad;

  chk_oe_pair: assert property (dqOe == parityIoOe)
    else $error("parity enable differs from data enable");
  chk_stall_hold: assert property (clkQualifyN |=> $stable(dqOut) && $stable(parityIoOut))
    else $error("read data moved on a masked edge");
  chk_desel_float: assert property ((load && !selOk) ##1 !clkQualifyN |=> !dqOe)
    else $error("bus driven after a deselect");
  chk_write_float: assert property ((load && selOk && !writeN) ##1 !clkQualifyN |=> !dqOe)
    else $error("bus driven in write data phase");
  chk_read_drive: assert property ((!outEnN && !sleepReq && !sleepActive) [*4] ##0
    (load && selOk && writeN) ##1 (!clkQualifyN && !outEnN && !sleepReq) |=> dqOe)
    else $error("read data not driven");
  chk_oe_off: assert property (outEnN [*4] |-> !dqOe && !parityIoOe)
    else $error("bus driven with output enable off");
  chk_sleep_quiet: assert property (sleepActive [*2] |-> !dqOe)
    else $error("bus driven while asleep");
  chk_sleep_enter: assert property (sleepReq [*4] |-> sleepActive)
    else $error("sleep not entered");
  chk_sleep_exit: assert property (!sleepReq [*4] |-> !sleepActive)
    else $error("sleep not left");
endmodule

bind pss_sram_port pss_sram_port_asserts chk (.mclk(mclk), .rst(rst),
  .clkQualifyN(clkQualifyN), .chipSel1N(chipSel1N), .chipSel2(chipSel2),
  .chipSel3N(chipSel3N), .advanceLoad(advanceLoad), .writeN(writeN), .outEnN(outEnN),
  .sleepReq(sleepReq), .dqOut(dqOut), .parityIoOut(parityIoOut), .dqOe(dqOe),
  .parityIoOe(parityIoOe), .sleepActive(sleepActive));

// ===== tb/pss_sram_port_tb.sv
// Bench: random bus traffic checked against a word model of the array.
// Assumes the host model resolves the shared data lines.
`timescale 1ns/1ps
module pss_sram_port_tb;
  import pss_pkg::*;
  typedef struct {int op, ad, ln; pss_word_t dat;} pss_beat_t;
  logic mclk, rst, clkQualifyN, chipSel1N, chipSel2, chipSel3N, advanceLoad, writeN;
  logic outEnN, sleepReq, burstMode, dqOe, parityIoOe, sleepActive, hostDrv;
  logic oeReq, slReq, modeReq, oeOn, asleep, held, lastOe, lanesAll;
  pss_lanes_t laneWrN, parityIoOut;
  pss_addr_t addr;
  logic [DATA_W-1:0] dqOut;
  pss_word_t hostWord, busWord, lastOut;
  pss_word_t mem[int];
  pss_beat_t q[2];
  int checks, mismatches, lastType, base, cnt, r;

  pss_sram_port uut (.mclk(mclk), .rst(rst), .clkQualifyN(clkQualifyN),
    .chipSel1N(chipSel1N), .chipSel2(chipSel2), .chipSel3N(chipSel3N),
    .advanceLoad(advanceLoad), .writeN(writeN), .laneWrN(laneWrN), .addr(addr),
    .outEnN(outEnN), .sleepReq(sleepReq), .burstMode(burstMode),
    .dqIn(busWord[DATA_W-1:0]), .dqOut(dqOut), .dqOe(dqOe),
    .parityIoIn(busWord[WORD_W-1:DATA_W]), .parityIoOut(parityIoOut),
    .parityIoOe(parityIoOe), .sleepActive(sleepActive));
  pss_host_model host (.dqOut(dqOut), .parityIoOut(parityIoOut), .dqOe(dqOe),
    .hostWord(hostWord), .hostDrv(hostDrv), .busWord(busWord));

  task automatic cmpWord(input string n, input pss_word_t e, input pss_word_t g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic cmpBit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask

  // Op codes: 0 deselect, 1 read, 2 write, 3 advance, 4 masked edge
  task automatic drive(input int op, input int a);
    int k, ln, ty;
    pss_word_t d;
    k = $urandom % 3;
    ln = lanesAll ? 0 : $urandom % 16;
    d = pss_word_t'({$urandom, $urandom});
    if (a < 0) a = 'h1ABC0 + $urandom % 8;
    if (op == 3 && lastType == 0) op = 0;
    if (op == 3) begin
      cnt++;
      ty = lastType;
      a = (base & 'h1FFFC) | (modeReq ? (base ^ cnt) & 3 : (base + cnt) & 3);
    end else if (op != 4) begin
      ty = (op == 0 || asleep) ? 0 : op;
      lastType = ty;
      base = a;
      cnt = 0;
    end
    chipSel1N <= op == 0 && k == 0;
    chipSel2 <= !(op == 0 && k == 1);
    chipSel3N <= op == 0 && k == 2;
    advanceLoad <= op == 3;
    writeN <= !(op == 2 || op == 4);
    laneWrN <= pss_lanes_t'(ln);
    addr <= pss_addr_t'(a);
    if (op != 4) begin
      q[1] = q[0];
      q[0] = '{ty, a, ln, d};
    end
  endtask

  task automatic step(input int op, input int a = -1);
    pss_beat_t t;
    logic ign;
    pss_word_t w;
    @(posedge mclk);
    ign = held;
    t = q[1];
    if (ign) t.op = -1;
    if (t.op == 2) begin
      hostWord <= t.dat;
      hostDrv <= 1'b1;
    end else if (!ign) begin
      hostDrv <= 1'b0;
    end
    held = op == 4;
    clkQualifyN <= held;
    outEnN <= oeReq;
    sleepReq <= slReq;
    burstMode <= modeReq;
    drive(op, a);
    #1;
    w = {parityIoOut, dqOut};
    if (ign) begin
      cmpWord("stall data", lastOut, w);
      cmpBit("stall oe", lastOe, dqOe);
      cmpBit("stall parity oe", lastOe, parityIoOe);
    end else begin
      cmpBit("bus drive", t.op == 1 && oeOn && !asleep, dqOe);
      cmpBit("parity drive", t.op == 1 && oeOn && !asleep, parityIoOe);
    end
    if (t.op == 1) cmpWord("read data", mem[t.ad], w);
    if (t.op == 2) begin
      w = mem.exists(t.ad) ? mem[t.ad] : '0;
      for (int i = 0; i < LANES; i++) begin
        if (!t.ln[i]) begin
          w[i*BYTE_W +: BYTE_W] = t.dat[i*BYTE_W +: BYTE_W];
          w[DATA_W + i] = t.dat[DATA_W + i];
        end
      end
      mem[t.ad] = w;
    end
    lastOut = {parityIoOut, dqOut};
    lastOe = dqOe;
  endtask

  task automatic rnd(input int n);
    repeat (n) begin
      r = $urandom % 10;
      step(r < 1 ? 0 : r < 4 ? 1 : r < 7 ? 2 : r < 9 ? 3 : 4);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Run is about 400 cycles
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    {rst, chipSel1N, chipSel3N, writeN, oeOn, modeReq, burstMode, lanesAll} = 8'hFF;
    {clkQualifyN, chipSel2, advanceLoad, hostDrv, oeReq, slReq} = 6'h00;
    {outEnN, sleepReq, asleep, held} = 4'h0;
    laneWrN = 4'hF;
    addr = '0;
    hostWord = '0;
    r = $urandom(55006);
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) step(0);
    for (int i = 0; i < 8; i++) step(2, 'h1ABC0 + i);
    lanesAll = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      modeReq = m[0];
      repeat (4) step(0);
      rnd(150);
    end
    oeReq = 1'b1;
    repeat (4) step(0);
    oeOn = 1'b0;
    rnd(30);
    oeReq = 1'b0;
    repeat (4) step(0);
    oeOn = 1'b1;
    slReq = 1'b1;
    repeat (5) step(0);
    asleep = 1'b1;
    cmpBit("sleep", 1'b1, sleepActive);
    repeat (6) step(1);
    slReq = 1'b0;
    asleep = 1'b0;
    repeat (5) step(0);
    cmpBit("wake", 1'b0, sleepActive);
    rnd(40);
    finish_test();
  end
endmodule
